// file: include/fault_bank_pkg.sv
// constants shared by the fault status bank and its helpers
// assumes a 32-bit axi4-lite register bus; offsets are register indices
package fault_bank_pkg;

  // ------------------------------------------------------------
  // register indices (printed offsets are not word multiples)
  // ------------------------------------------------------------
  localparam logic [15:0] ALARM_CAUSE_IDX = 16'h7F16;
  localparam logic [15:0] LIVE_FAULT_IDX = 16'h7F19;
  localparam logic [15:0] CELL_UV_IDX = 16'h7F1C;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'h7F30;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h7F31;

  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int FAULT_W = 18;
  localparam int CELL_W = 16;
  localparam int ADDR_W = 18;
  localparam logic [FAULT_W-1:0] FAULT_RST = 18'h00000;
  localparam logic [CELL_W-1:0] CELL_RST = 16'h0000;
  localparam logic [31:0] IRQ_MASK_RST = 32'h00000000;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int BIT_CELL_OV = 0;
  localparam int BIT_PACK_UV = 4;
  localparam int BIT_CHG_OC = 5;
  localparam int BIT_DSG_SC = 8;
  localparam int BIT_FE_OT = 9;
  localparam int BIT_BOARD_OT = 12;
  localparam int BIT_OPEN_WIRE = 13;
  localparam int BIT_MISMATCH = 14;
  localparam int BIT_SW_DRIVER = 15;
  localparam int BIT_SYSTEM = 16;
  localparam int BIT_SENSING = 17;
  localparam int BIT_CELL15 = 14;
  localparam int BIT_CELL16 = 15;

  // irq status layout: bit 0 alarm rise, bit 1 live fault rise, bit 2 cell uv rise
  localparam int IRQ_W = 3;
  localparam int IRQ_ALARM = 0;
  localparam int IRQ_LIVE = 1;
  localparam int IRQ_CELL = 2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // word byte address of an index
  function automatic logic [ADDR_W-1:0] idx_to_addr(input logic [15:0] idx);
    return {idx, 2'h0};
  endfunction

endpackage

// file: include/flag_sync_if.sv
// carries one synchronised group of fault flags between modules
// assumes both ends run on aclk
`timescale 1ns/1ps
interface flag_sync_if #(
  parameter int W = 18
);
  logic [W-1:0] flags;
  logic [W-1:0] rise;

  modport src (output flags, output rise);
  modport dst (input flags, input rise);
endinterface

// file: hw/flag_sync.sv
// two-stage synchroniser for a group of analogue detector levels
// assumes detector outputs are asynchronous to aclk
`timescale 1ns/1ps
module flag_sync
  import fault_bank_pkg::*;
#(
  parameter int W = 18
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low active
  input wire logic [W-1:0] raw, // detector levels
  flag_sync_if.src out // synced flags and rises
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } sync_s;

  sync_s st_ff;
  sync_s nxt_st;

  // refused at elaboration: the bus word holds at most 32 flags
  if (W < 1 || W > 32) begin : g_bad_w
    $error("flag_sync width out of range");
  end

  // ------------------------------------------------------------
  // three flops; only sync and prev feed logic
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = raw;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign out.flags = st_ff.sync;
  // rising edges, for the interrupt logic
  assign out.rise = st_ff.sync & ~st_ff.prev;
endmodule // flag_sync

// file: hw/irq_ctrl.sv
// sticky interrupt status with mask and one level output
// assumes write strobes come from the bus slave on aclk
`timescale 1ns/1ps
module irq_ctrl
  import fault_bank_pkg::*;
#(
  parameter int W = 3
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, low active
  input wire logic [W-1:0] event_in, // one-cycle events
  input wire logic clr_we, // write to status
  input wire logic [W-1:0] clr_data, // ones clear bits
  input wire logic mask_we, // write to mask
  input wire logic [W-1:0] mask_data, // new mask
  output logic [W-1:0] status, // sticky bits
  output logic [W-1:0] mask, // enable bits
  output logic irq // level interrupt
);

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic irq;
  } irq_s;

  irq_s st_ff;
  irq_s nxt_st;

  // refused at elaboration: the bus word holds at most 32 bits
  if (W < 1 || W > 32) begin : g_bad_w
    $error("irq_ctrl width out of range");
  end

  // ------------------------------------------------------------
  // set wins over a same-cycle clear so no event is lost
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (clr_we) begin
      nxt_st.status = st_ff.status & ~clr_data;
    end
    nxt_st.status = nxt_st.status | event_in;
    if (mask_we) begin
      nxt_st.mask = mask_data;
    end
    nxt_st.irq = |(nxt_st.status & nxt_st.mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign status = st_ff.status;
  assign mask = st_ff.mask;
  assign irq = st_ff.irq;
endmodule // irq_ctrl

// file: hw/fault_status_bank.sv
// fault status bank of a battery monitor with read-only flag words, axi4-lite slave
// assumes detector levels arrive asynchronously; one clock aclk
// assumes one write and one read in flight at most on the bus
// assumes alarm causes are latched by the detectors themselves
//
// Overview of operation
// - alarm bit 14 follows mismatch alarm
// - alarm bit 15 follows switch driver alarm
// - alarm bit 16 follows system fault alarm
// - alarm bit 17 follows sensing fault alarm
// - live bits 0-4 show voltage faults
// - live bits 5-8 show current faults
// - live bits 9-12 show temperature faults
// - live bits 13-14 open wire, mismatch
// - live bit 15 shows switch driver fault
// - live bits 16-17 system and sensing faults
// - cell uv bits 15,14 for cells 16,15
// - alarm bits 0-13 carry lower alarms
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module fault_status_bank
  import fault_bank_pkg::*;
(
  input wire logic aclk, // 100 MHz clock
  input wire logic aresetn, // sync reset, low active
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // byte address
  input wire logic s_axi_awvalid, // address valid
  output logic s_axi_awready, // address taken
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // data valid
  output logic s_axi_wready, // data taken
  // axi4-lite write response
  output logic [1:0] s_axi_bresp, // write status
  output logic s_axi_bvalid, // response valid
  input wire logic s_axi_bready, // response taken
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr, // byte address
  input wire logic s_axi_arvalid, // address valid
  output logic s_axi_arready, // address taken
  // axi4-lite read data
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read status
  output logic s_axi_rvalid, // data valid
  input wire logic s_axi_rready, // data taken
  // detector inputs, asynchronous levels
  input wire logic [FAULT_W-1:0] alarm_cause_in, // alarm-forcing faults
  input wire logic [FAULT_W-1:0] live_fault_in, // live faults
  input wire logic [CELL_W-1:0] cell_undervolt_in, // per-cell uv
  output logic irq // level interrupt
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // bank state outside the irq and sync blocks in one word: bus halves held, answers, flag copies;
  // the flag copies keep read data stable while a level moves underneath
  typedef struct packed {
    logic aw_held;
    logic [ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [FAULT_W-1:0] alarm;
    logic [FAULT_W-1:0] live;
    logic [CELL_W-1:0] cell_uv;
  } bank_s;

  bank_s st_ff;
  bank_s nxt_st;

  // ------------------------------------------------------------
  // register map, byte address four times the index
  // ------------------------------------------------------------
  // alarm_cause_flags 7F16: faults now forcing an alarm, bits 17..0
  // live_fault_flags 7F19: faults active at this moment, bits 17..0
  // cell_undervolt_flags 7F1C: bit k reports cell k+1
  // irq status 7F30: bit 0 alarm rise, bit 1 live rise, bit 2 cell rise
  // irq mask 7F31: one enable per status bit, resets to zero
  // any other word reads zero and answers slverr on either channel
  // the three flag words ignore writes but still answer okay

  // synchronised flag groups
  flag_sync_if #(.W(FAULT_W)) alarm_if ();
  flag_sync_if #(.W(FAULT_W)) live_if ();
  flag_sync_if #(.W(CELL_W)) cell_if ();

  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic wr_fire;
  logic irq_clr_we;
  logic irq_mask_we;

  // ------------------------------------------------------------
  // layout checks, refused at elaboration
  // ------------------------------------------------------------
  if (FAULT_W > 32 || CELL_W > 32 || IRQ_W > 32) begin : g_bad_width
    $error("flag group wider than a bus word");
  end
  if (BIT_SENSING >= FAULT_W || BIT_CELL16 >= CELL_W) begin : g_bad_field
    $error("flag position outside its register");
  end
  // the index is 16 bits and the byte lanes take two more
  if (ADDR_W != 18) begin : g_bad_addr
    $error("address width does not match index plus byte lanes");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  // a level needs three edges to show in a read: two synchroniser
  // flops, then the bank register; pulses shorter than a cycle may
  // be missed, which suits slow analogue detectors
  // alarm causes
  flag_sync #(.W(FAULT_W)) u_alarm_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(alarm_cause_in),
    .out(alarm_if.src)
  );

  // live faults
  flag_sync #(.W(FAULT_W)) u_live_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(live_fault_in),
    .out(live_if.src)
  );

  // per-cell under-voltage
  flag_sync #(.W(CELL_W)) u_cell_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(cell_undervolt_in),
    .out(cell_if.src)
  );

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a[ADDR_W-1:2] == idx;
  endfunction

  // word read mux; unmapped addresses read zero, is_mapped flags them
  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] a,
    input bank_s s,
    input logic [IRQ_W-1:0] ist,
    input logic [IRQ_W-1:0] imk
  );
    logic [31:0] d;
    d = 32'h00000000;
    if (addr_is(a, ALARM_CAUSE_IDX)) begin
      d[FAULT_W-1:0] = s.alarm;
    end else if (addr_is(a, LIVE_FAULT_IDX)) begin
      d[FAULT_W-1:0] = s.live;
    end else if (addr_is(a, CELL_UV_IDX)) begin
      d[CELL_W-1:0] = s.cell_uv;
    end else if (addr_is(a, IRQ_STATUS_IDX)) begin
      d[IRQ_W-1:0] = ist;
    end else if (addr_is(a, IRQ_MASK_IDX)) begin
      d[IRQ_W-1:0] = imk;
    end
    return d;
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return addr_is(a, ALARM_CAUSE_IDX) || addr_is(a, LIVE_FAULT_IDX) ||
           addr_is(a, CELL_UV_IDX) || addr_is(a, IRQ_STATUS_IDX) ||
           addr_is(a, IRQ_MASK_IDX);
  endfunction

  // ------------------------------------------------------------
  // handshake outputs
  // ------------------------------------------------------------
  // ready signals come from state only, so a master may look at them
  // anywhere in the cycle; every answer comes from flops
  // one write at a time: stop taking halves while a response waits
  assign s_axi_awready = !st_ff.aw_held && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_held && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  // writes to the flag words commit and answer okay but change nothing;
  // only the two irq words have a write path at all
  // write commits when both halves are held
  assign wr_fire = st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  // only the low byte lane reaches the narrow irq registers
  assign irq_clr_we = wr_fire && addr_is(st_ff.aw_addr, IRQ_STATUS_IDX) && st_ff.w_strb[0];
  assign irq_mask_we = wr_fire && addr_is(st_ff.aw_addr, IRQ_MASK_IDX) && st_ff.w_strb[0];

  // a new fault anywhere in a group raises its event
  assign irq_event[IRQ_ALARM] = |alarm_if.rise;
  assign irq_event[IRQ_LIVE] = |live_if.rise;
  assign irq_event[IRQ_CELL] = |cell_if.rise;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // flag words follow the synchronised levels bit for bit
    // lower alarm flags
    nxt_st.alarm[BIT_OPEN_WIRE:BIT_CELL_OV] = alarm_if.flags[BIT_OPEN_WIRE:BIT_CELL_OV];
    nxt_st.alarm[BIT_MISMATCH] = alarm_if.flags[BIT_MISMATCH];
    nxt_st.alarm[BIT_SW_DRIVER] = alarm_if.flags[BIT_SW_DRIVER];
    nxt_st.alarm[BIT_SYSTEM] = alarm_if.flags[BIT_SYSTEM];
    nxt_st.alarm[BIT_SENSING] = alarm_if.flags[BIT_SENSING];
    nxt_st.live[BIT_PACK_UV:BIT_CELL_OV] = live_if.flags[BIT_PACK_UV:BIT_CELL_OV];
    nxt_st.live[BIT_DSG_SC:BIT_CHG_OC] = live_if.flags[BIT_DSG_SC:BIT_CHG_OC];
    nxt_st.live[BIT_BOARD_OT:BIT_FE_OT] = live_if.flags[BIT_BOARD_OT:BIT_FE_OT];
    nxt_st.live[BIT_MISMATCH:BIT_OPEN_WIRE] = live_if.flags[BIT_MISMATCH:BIT_OPEN_WIRE];
    nxt_st.live[BIT_SW_DRIVER] = live_if.flags[BIT_SW_DRIVER];
    nxt_st.live[BIT_SENSING:BIT_SYSTEM] = live_if.flags[BIT_SENSING:BIT_SYSTEM];
    // lower cells share the word and pass straight through
    nxt_st.cell_uv[BIT_CELL15-1:0] = cell_if.flags[BIT_CELL15-1:0];
    nxt_st.cell_uv[BIT_CELL16:BIT_CELL15] = cell_if.flags[BIT_CELL16:BIT_CELL15];

    // a half that arrives early waits in the held flops for its partner,
    // and its ready drops so the master cannot overwrite it
    // write address and data, either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = is_mapped(st_ff.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // read: data registered one cycle after the address
    // a flag word read returns the bank register, never the raw pin
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = read_word(s_axi_araddr, st_ff, irq_status, irq_mask);
      nxt_st.rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.alarm <= FAULT_RST;
      st_ff.live <= FAULT_RST;
      st_ff.cell_uv <= CELL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  // a rise in any flag group sets its sticky bit; a level that stays
  // up raises no second event until it has dropped and risen again
  irq_ctrl #(.W(IRQ_W)) u_irq (
    .aclk(aclk),
    .aresetn(aresetn),
    .event_in(irq_event),
    .clr_we(irq_clr_we),
    .clr_data(st_ff.w_data[IRQ_W-1:0]),
    .mask_we(irq_mask_we),
    .mask_data(st_ff.w_data[IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

endmodule // fault_status_bank

// file: verification/fault_bank_checker.sv
// port assertions for the fault status bank
// assumes one clock aclk and a sync active-low reset
`timescale 1ns/1ps
module fault_bank_checker
  import fault_bank_pkg::*;
(
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // aw addr
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic [ADDR_W-1:0] s_axi_araddr, // ar addr
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic [1:0] s_axi_rresp, // r resp
  input wire logic s_axi_rvalid, // r valid
  input wire logic [FAULT_W-1:0] alarm_cause_in, // alarms
  input wire logic [FAULT_W-1:0] live_fault_in, // live
  input wire logic [CELL_W-1:0] cell_undervolt_in, // cells
  input wire logic irq // interrupt
);
  localparam logic [ADDR_W-1:0] A_AL = {ALARM_CAUSE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_LV = {LIVE_FAULT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_CU = {CELL_UV_IDX, 2'h0};
  logic [51:0] in_ff;
  logic [2:0] q_ff;
  logic rd;
  assign rd = s_axi_arvalid && s_axi_arready;
  // reads judged only once the synchroniser has caught up
  always_ff @(posedge aclk) begin
    in_ff <= {alarm_cause_in, live_fault_in, cell_undervolt_in};
    if (!aresetn || in_ff != {alarm_cause_in, live_fault_in, cell_undervolt_in}) begin
      q_ff <= 3'h0;
    end else if (q_ff != 3'h7) begin
      q_ff <= q_ff + 3'h1;
    end
  end
  // ----------------
  // properties
  // ----------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst_idle;
    $rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("busy after reset");
  property p_al_rd;
    rd && s_axi_araddr == A_AL && q_ff > 3'h3 |=> s_axi_rdata == {14'h0, $past(in_ff[51:34])};
  endproperty
  a_al_rd: assert property (p_al_rd) else $error("alarm flags wrong");
  property p_lv_rd;
    rd && s_axi_araddr == A_LV && q_ff > 3'h3 |=> s_axi_rdata == {14'h0, $past(in_ff[33:16])};
  endproperty
  a_lv_rd: assert property (p_lv_rd) else $error("live flags wrong");
  property p_cu_rd;
    rd && s_axi_araddr == A_CU && q_ff > 3'h3 |=> s_axi_rdata == {16'h0, $past(in_ff[15:0])};
  endproperty
  a_cu_rd: assert property (p_cu_rd) else $error("cell flags wrong");
  property p_bad_rd;
    rd && s_axi_araddr == 18'h00000 |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_bad_rd: assert property (p_bad_rd) else $error("hole read not refused");
  property p_lv_top;
    rd && s_axi_araddr == A_LV |=> s_axi_rresp == RESP_OKAY && s_axi_rdata[31:18] == 14'h0;
  endproperty
  a_lv_top: assert property (p_lv_top) else $error("live upper bits set");
  property p_wr_ok;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == A_LV
      |-> ##[1:4] s_axi_bvalid && s_axi_bresp == RESP_OKAY;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("flag write not okayed");
  property p_rd_lat;
    rd |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  cover property (rd && s_axi_araddr == A_AL && q_ff > 3'h3);
  cover property (irq);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule // fault_bank_checker

bind fault_status_bank fault_bank_checker fault_bank_checker_inst (.*);

// file: verification/battery_fault_status_bank_tb_top.sv
// self-checking bench for the fault status bank
// assumes the bench is the only axi4-lite master
`timescale 1ns/1ps
module battery_fault_status_bank_tb_top
  import fault_bank_pkg::*;
;
  logic aclk, aresetn, irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [FAULT_W-1:0] alarm_cause_in, live_fault_in;
  logic [CELL_W-1:0] cell_undervolt_in;
  int n_fail, comparisons;
  localparam logic [ADDR_W-1:0] A_AL = {ALARM_CAUSE_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_LV = {LIVE_FAULT_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_CU = {CELL_UV_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_IS = {IRQ_STATUS_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] A_IM = {IRQ_MASK_IDX, 2'h0};

  fault_status_bank fault_status_bank_inst (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------
  // helpers
  // ----------------
  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tmo();
    n_fail++;
    $display("[ERR] wait expected answer seen none");
    test_done();
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready is looked at on the falling edge, where it is settled
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt, bt;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      at = s_axi_awvalid && s_axi_awready;
      wt = s_axi_wvalid && s_axi_wready;
      bt = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (at) s_axi_awvalid <= 1'b0;
      if (wt) s_axi_wvalid <= 1'b0;
      if (bt) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge aclk);
      at = s_axi_arvalid && s_axi_arready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (s_axi_rvalid) begin
        @(posedge aclk);
        s_axi_rready <= 1'b0;
        return;
      end
      @(posedge aclk);
      if (at) s_axi_arvalid <= 1'b0;
    end
    tmo();
  endtask
  task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(nm, e, d);
    chk(nm, {30'h0, er}, {30'h0, r});
  endtask
  task automatic wr_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk(nm, {30'h0, er}, {30'h0, r});
  endtask
  // detector levels need three edges to reach the registers
  task automatic settle();
    repeat (4) @(posedge aclk);
  endtask
  task automatic wait_irq(input logic v);
    for (int n = 0; n < 20; n++) begin
      @(negedge aclk);
      if (irq === v) begin
        comparisons++;
        // hand back on a rising edge so the caller drives from there
        @(posedge aclk);
        return;
      end
    end
    tmo();
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_reset();
    rd_chk("alarm", A_AL, 32'h0, RESP_OKAY);
    rd_chk("live", A_LV, 32'h0, RESP_OKAY);
    rd_chk("cell", A_CU, 32'h0, RESP_OKAY);
    rd_chk("mask", A_IM, 32'h0, RESP_OKAY);
    rd_chk("status", A_IS, 32'h0, RESP_OKAY);
  endtask
  task automatic t_alarm();
    for (int i = 0; i < FAULT_W; i++) begin
      alarm_cause_in <= 18'h1 << i;
      settle();
      rd_chk("alarm", A_AL, 32'h1 << i, RESP_OKAY);
    end
    alarm_cause_in <= 18'h3FFFF;
    settle();
    rd_chk("alarm", A_AL, 32'h3FFFF, RESP_OKAY);
    rd_chk("live", A_LV, 32'h0, RESP_OKAY);
  endtask
  task automatic t_live();
    for (int i = 0; i < FAULT_W; i++) begin
      live_fault_in <= 18'h1 << i;
      settle();
      rd_chk("live", A_LV, 32'h1 << i, RESP_OKAY);
    end
    rd_chk("cell", A_CU, 32'h0, RESP_OKAY);
  endtask
  task automatic t_cell();
    cell_undervolt_in <= 16'h8000;
    settle();
    rd_chk("cell16", A_CU, 32'h8000, RESP_OKAY);
    cell_undervolt_in <= 16'h4000;
    settle();
    rd_chk("cell15", A_CU, 32'h4000, RESP_OKAY);
  endtask
  task automatic t_ro();
    live_fault_in <= 18'h2A5A5;
    alarm_cause_in <= 18'h15A5A;
    settle();
    wr_chk("wr alarm", A_AL, 32'hFFFFFFFF, RESP_OKAY);
    wr_chk("wr live", A_LV, 32'h0, RESP_OKAY);
    wr_chk("wr cell", A_CU, 32'hFFFFFFFF, RESP_OKAY);
    rd_chk("alarm", A_AL, 32'h15A5A, RESP_OKAY);
    rd_chk("live", A_LV, 32'h2A5A5, RESP_OKAY);
    rd_chk("cell", A_CU, 32'h4000, RESP_OKAY);
    rd_chk("hole", 18'h00000, 32'h0, RESP_SLVERR);
    wr_chk("hole", 18'h00004, 32'h1, RESP_SLVERR);
  endtask
  task automatic t_irq();
    live_fault_in <= 18'h0;
    alarm_cause_in <= 18'h0;
    settle();
    // every group has risen once in the earlier scenarios
    rd_chk("status", A_IS, 32'h7, RESP_OKAY);
    wr_chk("clr", A_IS, 32'h7, RESP_OKAY);
    rd_chk("status", A_IS, 32'h0, RESP_OKAY);
    wr_chk("mask", A_IM, 32'h2, RESP_OKAY);
    // low lane off: the mask must keep its value
    s_axi_wstrb <= 4'hE;
    wr_chk("mask lane", A_IM, 32'h7, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd_chk("mask lane", A_IM, 32'h2, RESP_OKAY);
    wait_irq(1'b0);
    live_fault_in <= 18'h00020;
    wait_irq(1'b1);
    rd_chk("status", A_IS, 32'h2, RESP_OKAY);
    wr_chk("mask", A_IM, 32'h0, RESP_OKAY);
    wait_irq(1'b0);
    wr_chk("mask", A_IM, 32'h2, RESP_OKAY);
    wait_irq(1'b1);
    wr_chk("clr", A_IS, 32'h2, RESP_OKAY);
    wait_irq(1'b0);
    rd_chk("status", A_IS, 32'h0, RESP_OKAY);
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    alarm_cause_in = 18'h0;
    live_fault_in = 18'h0;
    cell_undervolt_in = 16'h0;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_alarm();
    t_live();
    t_cell();
    t_ro();
    t_irq();
    test_done();
  end
endmodule // battery_fault_status_bank_tb_top
